// ==== hw/crl_unit.sv ====
// condition register bit logic unit: decode, evaluate and write one cr bit
`timescale 1ns/1ps
`default_nettype none
module crl_unit
  import crl_pkg::*;
(
  // clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_reset_n,
  // instruction issue
  input  wire crl_pkg::crl_issue_s        i_issue,
  // exception register load from the rest of the pipeline
  input  wire logic                       i_xer_we,
  input  wire logic [crl_pkg::CRL_XER_W-1:0] i_xer_wdata,
  // state and status
  output logic [crl_pkg::CRL_WORD_W-1:0]  o_cr,
  output logic [crl_pkg::CRL_XER_W-1:0]   o_xer,
  output logic                            o_done,
  output logic                            o_illegal
);
  import crl_pkg::*;

  // timing: an instruction is taken on an edge with i_issue.valid high,
  // and o_cr, o_done and o_illegal show its outcome right after that same edge.
  // there is no stall input: back-to-back instructions are all taken or refused,
  // each reading the cr as the one before left it.

  // reset release path
  logic                  rst_meta_q;
  logic                  rst_sync_q;
  // architectural state and status
  logic [CRL_WORD_W-1:0] cr_q;
  logic [CRL_WORD_W-1:0] cr_d;
  logic [CRL_XER_W-1:0]  xer_q;
  logic [CRL_XER_W-1:0]  xer_d;
  logic                  done_q;
  logic                  illegal_q;
  // decode and datapath
  logic [CRL_POP_W-1:0]  pop_field;
  logic [CRL_XO_W-1:0]   xo_field;
  crl_dec_s              dec;
  logic                  take;
  logic                  refuse;
  logic                  bit_a;
  logic                  bit_b;
  logic                  result;
  logic [CRL_WORD_W-1:0] tgt_mask;
  logic [CRL_WORD_W-1:0] wr_bits;

  // field extract using msb-0 numbering
  function automatic logic [CRL_IDX_W-1:0] field5(
    input logic [CRL_WORD_W-1:0] w, input int msb0);
    field5 = w[CRL_WORD_W-1-msb0 -: CRL_IDX_W];
  endfunction : field5

  // primary opcode field, msb-0 bits 0-5
  function automatic logic [CRL_POP_W-1:0] pop_of(
    input logic [CRL_WORD_W-1:0] w);
    pop_of = w[CRL_WORD_W-1-CRL_POP_MSB -: CRL_POP_W];
  endfunction : pop_of

  // extended opcode field, msb-0 bits 21-30
  function automatic logic [CRL_XO_W-1:0] xo_of(
    input logic [CRL_WORD_W-1:0] w);
    xo_of = w[CRL_WORD_W-1-CRL_XO_MSB -: CRL_XO_W];
  endfunction : xo_of

  // cr bit i is word bit 31-i, matching the msb-0 view of software
  function automatic logic [CRL_IDX_W-1:0] cr_pos(
    input logic [CRL_IDX_W-1:0] idx);
    cr_pos = 5'h1f - idx;
  endfunction : cr_pos

  function automatic logic cr_bit(
    input logic [CRL_WORD_W-1:0] cr, input logic [CRL_IDX_W-1:0] idx);
    cr_bit = cr[cr_pos(idx)];
  endfunction : cr_bit

  // one-hot mask of the word bit that a cr index names
  function automatic logic [CRL_WORD_W-1:0] cr_mask(
    input logic [CRL_IDX_W-1:0] idx);
    cr_mask              = '0;
    cr_mask[cr_pos(idx)] = 1'b1;
  endfunction : cr_mask

  // map an extended opcode onto the internal one-hot operation code
  function automatic crl_op_e op_of_xo(input logic [CRL_XO_W-1:0] xo);
    case (xo)
      CRL_XO_ANDC: op_of_xo = CRL_OP_ANDC;
      CRL_XO_EQV:  op_of_xo = CRL_OP_EQV;
      CRL_XO_NAND: op_of_xo = CRL_OP_NAND;
      CRL_XO_NOR:  op_of_xo = CRL_OP_NOR;
      CRL_XO_OR:   op_of_xo = CRL_OP_OR;
      CRL_XO_ORC:  op_of_xo = CRL_OP_ORC;
      default:     op_of_xo = CRL_OP_NONE;
    endcase
  endfunction : op_of_xo

  // any code but none is one of the six recognised operations
  function automatic logic is_known(input crl_op_e op);
    is_known = (op != CRL_OP_NONE);
  endfunction : is_known

  // one operation on two operand bits
  function automatic logic eval_op(
    input crl_op_e op, input logic a, input logic b);
    case (op)
      CRL_OP_ANDC: eval_op = a & ~b;
      CRL_OP_EQV:  eval_op = ~(a ^ b);
      CRL_OP_NAND: eval_op = ~(a & b);
      CRL_OP_NOR:  eval_op = ~(a | b);
      CRL_OP_OR:   eval_op = a | b;
      CRL_OP_ORC:  eval_op = a | ~b;
      default:     eval_op = 1'b0;
    endcase
  endfunction : eval_op

  // the raw reset may let go at any moment; downstream flops only ever
  // see a release that is aligned to the clock
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // decode; word bit 0 (msb-0 bit 31) is never looked at
  always_comb begin
    logic [CRL_WORD_W-1:0] w;
    w         = i_issue.word;
    pop_field = pop_of(w);
    xo_field  = xo_of(w);
    dec.tgt   = field5(w, CRL_TGT_MSB);
    dec.src1  = field5(w, CRL_SRC1_MSB);
    dec.src2  = field5(w, CRL_SRC2_MSB);
    dec.op    = CRL_OP_NONE;
    if (pop_field == CRL_POP_CR) begin
      dec.op = op_of_xo(xo_field);
    end
  end

  // operands come from the registered cr, so a target that is also a
  // source sees the value from before this write
  assign bit_a  = cr_bit(cr_q, dec.src1);
  assign bit_b  = cr_bit(cr_q, dec.src2);
  assign result = eval_op(dec.op, bit_a, bit_b);

  // a valid cycle is either taken or refused, never both
  assign take   = i_issue.valid && is_known(dec.op);
  assign refuse = i_issue.valid && !is_known(dec.op);

  assign tgt_mask = cr_mask(dec.tgt);
  assign wr_bits  = {CRL_WORD_W{result}} & tgt_mask;

  // bits outside the mask keep their old value
  always_comb begin
    cr_d = cr_q;
    if (take) begin
      cr_d = (cr_q & ~tgt_mask) | wr_bits;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cr_q <= CRL_CR_RESET;
    end else begin
      cr_q <= cr_d;
    end
  end

  // only the pipeline load path moves the exception register
  always_comb begin
    xer_d = xer_q;
    if (i_xer_we) begin
      xer_d = i_xer_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      xer_q <= CRL_XER_RESET;
    end else begin
      xer_q <= xer_d;
    end
  end

  // done and illegal each follow take and refuse one cycle later, so back-to-back taken (or refused) instructions hold done (or illegal) high
  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      done_q <= 1'b0;
    end else begin
      done_q <= take;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= refuse;
    end
  end

  // outputs straight from their flops
  assign o_cr      = cr_q;
  assign o_xer     = xer_q;
  assign o_done    = done_q;
  assign o_illegal = illegal_q;
endmodule : crl_unit
`default_nettype wire

// ==== hw/crl_pkg.sv ====
// package: instruction fields, extended opcodes and carriers for crl unit
package crl_pkg;
  localparam int          CRL_WORD_W       = 32;
  localparam int          CRL_IDX_W        = 5;
  localparam int          CRL_XO_W         = 10;
  localparam int          CRL_POP_W        = 6;
  localparam int          CRL_XER_W        = 32;
  // bit positions, bit 0 is the most significant bit of the word
  localparam int          CRL_POP_MSB      = 0;
  localparam int          CRL_TGT_MSB      = 6;
  localparam int          CRL_SRC1_MSB     = 11;
  localparam int          CRL_SRC2_MSB     = 16;
  localparam int          CRL_XO_MSB       = 21;
  localparam logic [5:0]  CRL_POP_CR       = 6'h13;
  localparam logic [9:0]  CRL_XO_ANDC      = 10'h081;
  localparam logic [9:0]  CRL_XO_EQV       = 10'h121;
  localparam logic [9:0]  CRL_XO_NAND      = 10'h0e1;
  localparam logic [9:0]  CRL_XO_NOR       = 10'h021;
  localparam logic [9:0]  CRL_XO_OR        = 10'h1c1;
  localparam logic [9:0]  CRL_XO_ORC       = 10'h1a1;
  localparam logic [31:0] CRL_CR_RESET     = 32'h0000_0000;
  localparam logic [31:0] CRL_XER_RESET    = 32'h0000_0000;

  typedef enum logic [5:0] {
    CRL_OP_NONE = 6'h00,
    CRL_OP_ANDC = 6'h01,
    CRL_OP_EQV  = 6'h02,
    CRL_OP_NAND = 6'h04,
    CRL_OP_NOR  = 6'h08,
    CRL_OP_OR   = 6'h10,
    CRL_OP_ORC  = 6'h20
  } crl_op_e;

  typedef struct packed {
    logic [CRL_IDX_W-1:0] tgt;
    logic [CRL_IDX_W-1:0] src1;
    logic [CRL_IDX_W-1:0] src2;
    crl_op_e              op;
  } crl_dec_s;

  typedef struct packed {
    logic                  valid;
    logic [CRL_WORD_W-1:0] word;
  } crl_issue_s;
endpackage : crl_pkg

// ==== tb/crl_unit_sva.sv ====
// checker: port assertions for the cr bit logic unit
`timescale 1ns/1ps
`default_nettype none
module crl_unit_chk
  import crl_pkg::*;
(
  input wire logic                       i_sys_clk,
  input wire logic                       i_reset_n,
  input wire crl_pkg::crl_issue_s        i_issue,
  input wire logic                       i_xer_we,
  input wire logic [crl_pkg::CRL_XER_W-1:0] i_xer_wdata,
  input wire logic [crl_pkg::CRL_WORD_W-1:0] o_cr,
  input wire logic [crl_pkg::CRL_XER_W-1:0] o_xer,
  input wire logic                       o_done,
  input wire logic                       o_illegal
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic [31:0] w;
  logic [9:0]  x;
  logic        ok, good, a, b, a_q, b_q;
  logic [4:0]  t_q;
  assign w = i_issue.word;
  assign x = w[10:1];
  assign ok = i_issue.valid && w[31:26] == CRL_POP_CR;
  assign good = ok && x inside {CRL_XO_ANDC, CRL_XO_EQV, CRL_XO_NAND,
                                CRL_XO_NOR, CRL_XO_OR, CRL_XO_ORC};
  assign a = o_cr[31-w[20:16]];
  assign b = o_cr[31-w[15:11]];
  // operands captured at the taking edge, so a target that is also a source
  // is judged against the value it held before the write
  always_ff @(posedge i_sys_clk) begin
    t_q <= w[25:21];
    a_q <= a;
    b_q <= b;
  end
  a_done_on_take: assert property (good |=>
    o_done && !o_illegal) else $error("good op not flagged done");
  a_andc_result: assert property (ok && x == CRL_XO_ANDC |=>
    o_cr[31-t_q] == (a_q & !b_q)) else $error("andc result wrong");
  a_eqv_result: assert property (ok && x == CRL_XO_EQV |=>
    o_cr[31-t_q] == (a_q == b_q)) else $error("eqv result wrong");
  a_nand_result: assert property (ok && x == CRL_XO_NAND |=>
    o_cr[31-t_q] == !(a_q & b_q)) else $error("nand result wrong");
  a_nor_result: assert property (ok && x == CRL_XO_NOR |=>
    o_cr[31-t_q] == !(a_q | b_q)) else $error("nor result wrong");
  a_or_result: assert property (ok && x == CRL_XO_OR |=>
    o_cr[31-t_q] == (a_q | b_q)) else $error("or result wrong");
  a_orc_result: assert property (ok && x == CRL_XO_ORC |=>
    o_cr[31-t_q] == (a_q | !b_q)) else $error("orc result wrong");
  a_refuse_bad_op: assert property (i_issue.valid && !good |=>
    o_illegal && !o_done && $stable(o_cr)) else $error("bad op not refused");
  a_xer_kept: assert property (!i_xer_we |=>
    $stable(o_xer)) else $error("exception reg changed");
  a_other_bits_kept: assert property (good |=>
    ((o_cr ^ $past(o_cr)) & ~(32'h1 << (31 - t_q))) == 32'h0)
    else $error("non-target cr bit changed");
endmodule : crl_unit_chk
bind crl_unit crl_unit_chk i_chk (
  .i_sys_clk  (i_sys_clk),
  .i_reset_n  (i_reset_n),
  .i_issue    (i_issue),
  .i_xer_we   (i_xer_we),
  .i_xer_wdata(i_xer_wdata),
  .o_cr       (o_cr),
  .o_xer      (o_xer),
  .o_done     (o_done),
  .o_illegal  (o_illegal)
);
`default_nettype wire

// ==== tb/tb_crl_unit.sv ====
// testbench: directed scenarios for the cr bit logic unit
`timescale 1ns/1ps
`default_nettype none
module tb_crl_unit;
  import crl_pkg::*;
  logic        clk = 0, rst_n = 0, xwe = 0, done, ill;
  crl_issue_s  iss = '0;
  logic [31:0] xd = '0, cr, xer, m = '0;
  int          failures = 0, tests_run = 0;
  logic [9:0]  xo [6] = '{CRL_XO_ANDC, CRL_XO_EQV, CRL_XO_NAND,
                          CRL_XO_NOR, CRL_XO_OR, CRL_XO_ORC};
  always #12.5 clk = ~clk;
  crl_unit i_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_issue(iss),
    .i_xer_we(xwe), .i_xer_wdata(xd), .o_cr(cr), .o_xer(xer),
    .o_done(done), .o_illegal(ill));
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (e !== g) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  function automatic logic f(input logic [9:0] x, input logic p, q);
    case (x)
      CRL_XO_ANDC: return p & ~q;
      CRL_XO_EQV:  return ~(p ^ q);
      CRL_XO_NAND: return ~(p & q);
      CRL_XO_NOR:  return ~(p | q);
      CRL_XO_OR:   return p | q;
      default:     return p | ~q;
    endcase
  endfunction : f
  // one instruction per call; valid stays up so calls run back to back
  task automatic step(input logic [9:0] x, input logic [4:0] t, a, b,
                      input logic [5:0] p = CRL_POP_CR, input logic r = 0);
    logic ok;
    ok = p == CRL_POP_CR && x inside {xo};
    iss = {1'b1, p, t, a, b, x, r};
    @(posedge clk);
    if (ok) m[31-t] = f(x, m[31-a], m[31-b]);
    #2;
    chk("cr", m, cr);
    chk("done", {31'h0, ok}, {31'h0, done});
    chk("illegal", {31'h0, !ok}, {31'h0, ill});
  endtask : step
  task automatic t_ops;
    for (int i = 0; i < 30; i++)
      step(xo[i%6], 5'(i*7), 5'(i*3), 5'(i*5+1));
  endtask : t_ops
  task automatic t_self;
    step(CRL_XO_ORC, 5'h04, 5'h08, 5'h04);
    step(CRL_XO_EQV, 5'h04, 5'h08, 5'h04);
    step(CRL_XO_NAND, 5'h09, 5'h09, 5'h09);
  endtask : t_self
  task automatic t_bad;
    step(10'h101, 5'h01, 5'h02, 5'h03);
    step(CRL_XO_OR, 5'h01, 5'h02, 5'h03, 6'h1f);
    step(CRL_XO_NOR, 5'h1f, 5'h00, 5'h1f, CRL_POP_CR, 1'b1);
  endtask : t_bad
  task automatic t_xer;
    iss.valid = 0;
    xwe = 1;
    xd = 32'ha5c3_0f96;
    @(posedge clk);
    #2 xwe = 0;
    chk("xer load", xd, xer);
    chk("done idle", 32'h0, {31'h0, done});
    chk("illegal idle", 32'h0, {31'h0, ill});
    step(CRL_XO_NOR, 5'h00, 5'h11, 5'h12);
    step(CRL_XO_ANDC, 5'h1f, 5'h00, 5'h05);
    chk("xer kept", 32'ha5c3_0f96, xer);
    iss.valid = 0;
  endtask : t_xer
  task end_of_test;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge clk);
    #2 rst_n = 1;
    repeat (3) @(posedge clk);
    #2;
    t_ops;
    t_self;
    t_bad;
    t_xer;
    end_of_test;
  end
  // about fifty cycles of work, so this leaves ample margin
  initial begin
    #20000;
    failures++;
    end_of_test;
  end
endmodule : tb_crl_unit
`default_nettype wire
